// ==== src/elsb_pkg.sv ====
/*
 * Shared constants for the error log sector builder: APB map, sector
 * layout offsets, reset values and writer FSM states.
 * Assumes a 32-bit APB with 12-bit byte addresses and one clock domain.
 */
`default_nettype none

package elsb_pkg;

    // APB byte map
    localparam logic [11:0] ADDR_DIR_BASE = 12'h000;
    localparam logic [11:0] ADDR_ELOG_BASE = 12'h200;
    localparam logic [11:0] ADDR_CTRL = 12'h400;
    localparam logic [11:0] ADDR_STATUS = 12'h404;
    localparam logic [11:0] ADDR_COUNT = 12'h408;

    // Control and status fields
    localparam int CTRL_DIR_EN_BIT = 0;
    localparam logic CTRL_DIR_EN_RST = 1'b1;
    localparam int STAT_IDX_LSB = 0;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_OVR_BIT = 9;

    // Log directory contents
    localparam logic [15:0] DIR_VERSION = 16'h0001;
    localparam logic [15:0] DIR_NO_VERSION = 16'h0000;
    localparam logic [7:0] DIR_HOST_FIRST = 8'h80;
    localparam logic [7:0] DIR_HOST_LAST = 8'h9f;
    localparam logic [15:0] DIR_HOST_SECTORS = 16'h0010;
    localparam logic [7:0] DIR_ELOG_ADDR = 8'h03;
    localparam logic [15:0] DIR_ELOG_SECTORS = 16'h0001;

    // Error log sector layout
    localparam logic [7:0] ELOG_VERSION = 8'h01;
    localparam logic [8:0] ELOG_OFS_VERSION = 9'h000;
    localparam logic [8:0] ELOG_OFS_INDEX = 9'h002;
    localparam logic [8:0] ELOG_OFS_REC = 9'h004;
    localparam logic [8:0] ELOG_OFS_COUNT = 9'h1f4;
    localparam logic [8:0] ELOG_OFS_CSUM = 9'h1ff;
    localparam int ELOG_SLOTS = 4;
    localparam int REC_BYTES = 124;
    localparam int REC_AREA = 496;
    localparam int CMD_SNAP_BYTES = 18;
    localparam int ERR_SNAP_BYTES = 34;
    localparam int CMD_HIST = 5;
    localparam logic [15:0] ERR_COUNT_MAX = 16'hffff;

    // Task file register selectors
    localparam logic [2:0] TF_DEVCTL = 3'h0;
    localparam logic [2:0] TF_FEAT = 3'h1;
    localparam logic [2:0] TF_COUNT = 3'h2;
    localparam logic [2:0] TF_SECTOR = 3'h3;
    localparam logic [2:0] TF_CYL_LO = 3'h4;
    localparam logic [2:0] TF_CYL_HI = 3'h5;
    localparam logic [2:0] TF_DEVHEAD = 3'h6;
    localparam logic [2:0] TF_COMMAND = 3'h7;

    // Power state codes for the state byte low nibble
    localparam logic [3:0] PWR_UNKNOWN = 4'h0;
    localparam logic [3:0] PWR_SLEEP = 4'h1;
    localparam logic [3:0] PWR_STANDBY = 4'h2;
    localparam logic [3:0] PWR_ACTIVE = 4'h3;
    localparam logic [3:0] PWR_SELFTEST = 4'h4;

    // Record writer states
    typedef enum logic [1:0] {
        ST_CLEAR = 2'b00,
        ST_IDLE = 2'b01,
        ST_WRITE = 2'b10
    } elsb_state_t;

endpackage

`default_nettype wire

// ==== src/elsb_snap.sv ====
/*
 * Command history and record image builder. Tracks the task file shadow
 * registers, keeps the last five command snapshots and assembles the
 * 124-byte record image (byte 0 in the low bits) for the current error.
 * Assumes all inputs are on the same clock as the instantiating block.
 */
`timescale 1ns/1ps
`default_nettype none

module elsb_snap #(
    parameter logic [3:0] STATE_HI = 4'h0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Task file writes
    input wire logic tf_we,
    input wire logic [2:0] tf_reg,
    input wire logic [7:0] tf_wdata,
    input wire logic [31:0] ts_ms,
    input wire logic [3:0] power_state,
    // Error snapshot fields, low byte read with HOB clear
    input wire logic [7:0] err_code,
    input wire logic [15:0] err_count,
    input wire logic [15:0] err_sector,
    input wire logic [15:0] err_cyl_lo,
    input wire logic [15:0] err_cyl_hi,
    input wire logic [7:0] err_devhead,
    input wire logic [7:0] err_status,
    input wire logic [15:0] life_hours,
    // Assembled record
    output logic [8*elsb_pkg::REC_BYTES-1:0] rec_img
);

    localparam int CW = 8 * elsb_pkg::CMD_SNAP_BYTES;

    logic [7:0] devctl_r;
    logic [7:0] devhead_r;
    logic [15:0] feat_r;
    logic [15:0] count_r;
    logic [15:0] sector_r;
    logic [15:0] cyl_lo_r;
    logic [15:0] cyl_hi_r;
    logic [7:0] state_r;
    logic [CW-1:0] hist_r [elsb_pkg::CMD_HIST];
    logic [CW-1:0] cmd_snap;
    logic [8*elsb_pkg::ERR_SNAP_BYTES-1:0] err_snap;

    // Shadow registers: a write to a 16-bit pair moves the current value into the high byte; devctl and devhead are overwritten
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            devctl_r <= 8'h00;
            devhead_r <= 8'h00;
            feat_r <= 16'h0000;
            count_r <= 16'h0000;
            sector_r <= 16'h0000;
            cyl_lo_r <= 16'h0000;
            cyl_hi_r <= 16'h0000;
        end else if (tf_we) begin
            case (tf_reg)
                elsb_pkg::TF_DEVCTL: devctl_r <= tf_wdata;
                elsb_pkg::TF_FEAT: feat_r <= {feat_r[7:0], tf_wdata};
                elsb_pkg::TF_COUNT: count_r <= {count_r[7:0], tf_wdata};
                elsb_pkg::TF_SECTOR: sector_r <= {sector_r[7:0], tf_wdata};
                elsb_pkg::TF_CYL_LO: cyl_lo_r <= {cyl_lo_r[7:0], tf_wdata};
                elsb_pkg::TF_CYL_HI: cyl_hi_r <= {cyl_hi_r[7:0], tf_wdata};
                elsb_pkg::TF_DEVHEAD: devhead_r <= tf_wdata;
                default: ;
            endcase
        end
    end

    // Snapshot taken as the opcode is written, reserved byte zero
    assign cmd_snap = {ts_ms, 8'h00, tf_wdata, devhead_r, cyl_hi_r, cyl_lo_r,
                       sector_r, count_r, feat_r, devctl_r};

    // History shifts toward slot 0 so slot 0 is the oldest command
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < elsb_pkg::CMD_HIST; i++) begin
                hist_r[i] <= '0;
            end
            state_r <= 8'h00;
        end else if (tf_we && tf_reg == elsb_pkg::TF_COMMAND) begin
            for (int i = 0; i < elsb_pkg::CMD_HIST - 1; i++) begin
                hist_r[i] <= hist_r[i+1];
            end
            hist_r[elsb_pkg::CMD_HIST-1] <= cmd_snap;
            state_r <= {STATE_HI, power_state};
        end
    end

    // Error snapshot; vendor extended bytes are left zero
    assign err_snap = {life_hours, state_r, 152'h0, err_status, err_devhead,
                       err_cyl_hi, err_cyl_lo, err_sector, err_count,
                       err_code, 8'h00};

    // Five commands oldest first, then the error snapshot at 5Ah
    assign rec_img = {err_snap, hist_r[4], hist_r[3], hist_r[2], hist_r[1],
                      hist_r[0]};

endmodule // elsb_snap

`default_nettype wire

// ==== src/elsb_top.sv ====
/*
 * Error log sector builder: log directory and extended comprehensive error
 * log sectors, readable word by word over APB, built from task file writes
 * and device error events.
 * Assumes an APB3 master on MCLK and event inputs from logic on MCLK.
 */
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Directory starts with version word 0001h
// - Sector counts per address, low byte first
// - Addresses 80h-9Fh report sixteen sectors
// - Rejected commands create no error record
// - Fixed error log sector byte layout
// - Error log version byte is 01h
// - Index names newest record, zero initially
// - Four records reused as circular buffer
// - Unwritten record slots read all zero
// - Record: five command snapshots, one error
// - Command snapshot fields at fixed offsets
// - Low byte newest write, high previous
// - Error snapshot fields at fixed offsets
// - Error pairs: HOB clear low, set high
// - State byte holds power state code
// - Lifetime count of device errors only
// - Lifetime count saturates at maximum
// - Last byte makes sector sum zero
module elsb_top #(
    parameter logic [3:0] STATE_HI = 4'h0
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Task file writes from the command decoder
    input wire logic TF_WE,
    input wire logic [2:0] TF_REG,
    input wire logic [7:0] TF_WDATA,
    input wire logic [31:0] TS_MS,
    input wire logic [3:0] POWER_STATE,
    // Error report from the device
    input wire logic ERR_VALID,
    input wire logic ERR_REJECTED,
    input wire logic [7:0] ERR_CODE,
    input wire logic [15:0] ERR_COUNT_PAIR,
    input wire logic [15:0] ERR_SECTOR_PAIR,
    input wire logic [15:0] ERR_CYL_LO_PAIR,
    input wire logic [15:0] ERR_CYL_HI_PAIR,
    input wire logic [7:0] ERR_DEVHEAD,
    input wire logic [7:0] ERR_STATUS,
    input wire logic [15:0] LIFE_HOURS,
    // Status
    output logic LOG_BUSY
);

    localparam int RB = elsb_pkg::REC_BYTES;

    elsb_pkg::elsb_state_t state_r;
    logic [8:0] ptr_r;
    logic [2:0] idx_r;
    logic [2:0] slot_r;
    logic [15:0] cnt_r;
    logic [7:0] rec_sum_r;
    logic dir_en_r;
    logic ovr_r;
    logic [8*RB-1:0] frame_r;
    logic [8*RB-1:0] rec_img;
    logic [7:0] rec_mem [elsb_pkg::REC_AREA];
    logic [15:0] dir_r [256];
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic busy_r;

    logic err_ok;
    logic accept;
    logic [8:0] wr_addr;
    logic [7:0] wr_byte;
    logic [7:0] old_byte;
    logic mem_we;
    logic acc_start;
    logic acc_done;
    logic [31:0] rd_word;
    logic rd_err;
    logic [7:0] csum;

    // Is a directory entry fixed by the layout rather than stored
    function automatic logic dir_fixed(input logic [7:0] a);
        dir_fixed = (a == 8'h00) ||
                    (a >= elsb_pkg::DIR_HOST_FIRST && a <= elsb_pkg::DIR_HOST_LAST);
    endfunction

    // Directory word for one log address
    function automatic logic [15:0] dir_entry(input logic [7:0] a, input logic en,
                                              input logic [15:0] stored);
        if (a == 8'h00) begin
            dir_entry = en ? elsb_pkg::DIR_VERSION : elsb_pkg::DIR_NO_VERSION;
        end else if (dir_fixed(a)) begin
            dir_entry = elsb_pkg::DIR_HOST_SECTORS;
        end else begin
            dir_entry = stored;
        end
    endfunction

    elsb_snap #(
        .STATE_HI(STATE_HI)
    ) u_snap (
        .clk(MCLK),
        .rst_n(RST_N),
        .tf_we(TF_WE),
        .tf_reg(TF_REG),
        .tf_wdata(TF_WDATA),
        .ts_ms(TS_MS),
        .power_state(POWER_STATE),
        .err_code(ERR_CODE),
        .err_count(ERR_COUNT_PAIR),
        .err_sector(ERR_SECTOR_PAIR),
        .err_cyl_lo(ERR_CYL_LO_PAIR),
        .err_cyl_hi(ERR_CYL_HI_PAIR),
        .err_devhead(ERR_DEVHEAD),
        .err_status(ERR_STATUS),
        .life_hours(LIFE_HOURS),
        .rec_img(rec_img)
    );

    // Only device-attributable errors go any further
    assign err_ok = ERR_VALID && !ERR_REJECTED;
    assign accept = err_ok && state_r == elsb_pkg::ST_IDLE;

    // Byte address of the writer inside the record area
    assign wr_addr = (state_r == elsb_pkg::ST_WRITE)
                   ? 9'((32'(slot_r) - 32'd1) * RB + 32'(ptr_r)) : ptr_r;
    assign wr_byte = (state_r == elsb_pkg::ST_WRITE) ? frame_r[ptr_r*8 +: 8] : 8'h00;
    assign old_byte = rec_mem[wr_addr];
    assign mem_we = (state_r == elsb_pkg::ST_WRITE) || (state_r == elsb_pkg::ST_CLEAR);

    // Record area store; no reset, the clear pass zeroes it instead
    always_ff @(posedge MCLK) begin
        if (mem_we) begin
            rec_mem[wr_addr] <= wr_byte;
        end
    end

    // Writer: clear all slots after reset, then one byte per cycle per record
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            state_r <= elsb_pkg::ST_CLEAR;
            ptr_r <= 9'h000;
            slot_r <= 3'h1;
            idx_r <= 3'h0;
            frame_r <= '0;
        end else begin
            case (state_r)
                elsb_pkg::ST_CLEAR: begin
                    if (ptr_r == 9'(elsb_pkg::REC_AREA - 1)) begin
                        state_r <= elsb_pkg::ST_IDLE;
                        ptr_r <= 9'h000;
                    end else begin
                        ptr_r <= ptr_r + 9'h001;
                    end
                end
                elsb_pkg::ST_IDLE: begin
                    if (accept) begin
                        state_r <= elsb_pkg::ST_WRITE;
                        frame_r <= rec_img;
                        slot_r <= (idx_r == 3'(elsb_pkg::ELOG_SLOTS)) ? 3'h1 : idx_r + 3'h1;
                        ptr_r <= 9'h000;
                    end
                end
                elsb_pkg::ST_WRITE: begin
                    if (ptr_r == 9'(RB - 1)) begin
                        state_r <= elsb_pkg::ST_IDLE;
                        idx_r <= slot_r;
                    end else begin
                        ptr_r <= ptr_r + 9'h001;
                    end
                end
                default: state_r <= elsb_pkg::ST_IDLE;
            endcase
        end
    end

    // Running byte sum of the record area, kept so the checksum is free
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            rec_sum_r <= 8'h00;
        end else if (state_r == elsb_pkg::ST_WRITE) begin
            rec_sum_r <= rec_sum_r + wr_byte - old_byte;
        end
    end

    // Lifetime count: every device error, even one that finds the writer busy
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            cnt_r <= 16'h0000;
        end else if (err_ok && cnt_r != elsb_pkg::ERR_COUNT_MAX) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // Checksum over version, index, count and records; reserved bytes are zero
    assign csum = 8'h00 - (elsb_pkg::ELOG_VERSION + {5'h00, idx_r} + cnt_r[7:0]
                           + cnt_r[15:8] + rec_sum_r);

    // APB phases: one wait state, then the answer
    assign acc_start = PSEL && PENABLE && !pready_r;
    assign acc_done = PSEL && PENABLE && pready_r;

    // Read mux and address decode
    always_comb begin
        logic [8:0] b;
        logic [7:0] a;
        b = 9'h000;
        a = 8'h00;
        rd_word = 32'h0000_0000;
        rd_err = 1'b0;
        if (PADDR[11:9] == elsb_pkg::ADDR_DIR_BASE[11:9]) begin
            a = {PADDR[8:2], 1'b0};
            rd_word = {dir_entry(a | 8'h01, dir_en_r, dir_r[a | 8'h01]),
                       dir_entry(a, dir_en_r, dir_r[a])};
            rd_err = PWRITE && PADDR[8:2] == 7'h00;
        end else if (PADDR[11:9] == elsb_pkg::ADDR_ELOG_BASE[11:9]) begin
            rd_err = PWRITE; // Sector image is read only
            for (int k = 0; k < 4; k++) begin
                b = {PADDR[8:2], 2'(k)};
                if (b == elsb_pkg::ELOG_OFS_VERSION) begin
                    rd_word[k*8 +: 8] = elsb_pkg::ELOG_VERSION;
                end else if (b == elsb_pkg::ELOG_OFS_INDEX) begin
                    rd_word[k*8 +: 8] = {5'h00, idx_r};
                end else if (b >= elsb_pkg::ELOG_OFS_REC && b < elsb_pkg::ELOG_OFS_COUNT) begin
                    rd_word[k*8 +: 8] = (state_r == elsb_pkg::ST_CLEAR)
                                      ? 8'h00 : rec_mem[b - elsb_pkg::ELOG_OFS_REC];
                end else if (b == elsb_pkg::ELOG_OFS_COUNT) begin
                    rd_word[k*8 +: 8] = cnt_r[7:0];
                end else if (b == elsb_pkg::ELOG_OFS_COUNT + 9'h001) begin
                    rd_word[k*8 +: 8] = cnt_r[15:8];
                end else if (b == elsb_pkg::ELOG_OFS_CSUM) begin
                    rd_word[k*8 +: 8] = csum;
                end else begin
                    rd_word[k*8 +: 8] = 8'h00;
                end
            end
        end else if (PADDR == elsb_pkg::ADDR_CTRL) begin
            rd_word[elsb_pkg::CTRL_DIR_EN_BIT] = dir_en_r;
        end else if (PADDR == elsb_pkg::ADDR_STATUS) begin
            rd_word[elsb_pkg::STAT_IDX_LSB +: 3] = idx_r;
            rd_word[elsb_pkg::STAT_BUSY_BIT] = busy_r;
            rd_word[elsb_pkg::STAT_OVR_BIT] = ovr_r;
        end else if (PADDR == elsb_pkg::ADDR_COUNT) begin
            rd_word[15:0] = cnt_r;
            rd_err = PWRITE;
        end else begin
            rd_err = 1'b1;
        end
    end

    // Bus answer registers; read data is captured as PREADY rises
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= acc_start;
            if (acc_start) begin
                pslverr_r <= rd_err;
                prdata_r <= PWRITE ? 32'h0000_0000 : rd_word;
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // Directory store; writes land only on the edge that completes the transfer
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            for (int i = 0; i < 256; i++) begin
                dir_r[i] <= (8'(i) == elsb_pkg::DIR_ELOG_ADDR) ? elsb_pkg::DIR_ELOG_SECTORS
                                                              : 16'h0000;
            end
        end else if (acc_done && PWRITE && PADDR[11:9] == elsb_pkg::ADDR_DIR_BASE[11:9]) begin
            for (int j = 0; j < 2; j++) begin
                if (!dir_fixed({PADDR[8:2], 1'(j)})) begin
                    dir_r[{PADDR[8:2], 1'(j)}] <= PWDATA[j*16 +: 16];
                end
            end
        end
    end

    // Control: directory present flag selects the version word
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            dir_en_r <= elsb_pkg::CTRL_DIR_EN_RST;
        end else if (acc_done && PWRITE && PADDR == elsb_pkg::ADDR_CTRL) begin
            dir_en_r <= PWDATA[elsb_pkg::CTRL_DIR_EN_BIT];
        end
    end

    // Overrun: an error that found the writer busy was counted but not recorded
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            ovr_r <= 1'b0;
        end else if (err_ok && state_r != elsb_pkg::ST_IDLE) begin
            ovr_r <= 1'b1;
        end else if (acc_done && PWRITE && PADDR == elsb_pkg::ADDR_STATUS
                     && PWDATA[elsb_pkg::STAT_OVR_BIT]) begin
            ovr_r <= 1'b0;
        end
    end

    // Busy flag out of a flop; set by reset for the clear pass, and the cycle after an error is accepted for a record
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            busy_r <= 1'b1;
        end else begin
            busy_r <= (state_r == elsb_pkg::ST_CLEAR && ptr_r != 9'(elsb_pkg::REC_AREA - 1))
                   || (state_r == elsb_pkg::ST_WRITE && ptr_r != 9'(RB - 1))
                   || accept;
        end
    end

    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign PRDATA = prdata_r;
    assign LOG_BUSY = busy_r;

endmodule // elsb_top

`default_nettype wire

// ==== dv/elsb_checker.sv ====
/* Checker for elsb_top: bus answer timing, refusals, record writer timing.
   Sees only the top ports and is bound onto every elsb_top. */
`timescale 1ns/1ps
`default_nettype none
module elsb_checker (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // Bus
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Error events and status
    input wire logic ERR_VALID,
    input wire logic ERR_REJECTED,
    input wire logic LOG_BUSY
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    logic [9:0] busy_cnt_r;
    logic seen_idle_r;
    // Busy run length; the clear pass is skipped since no idle spell precedes it
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            busy_cnt_r <= 10'h000;
            seen_idle_r <= 1'b0;
        end else begin
            busy_cnt_r <= LOG_BUSY ? busy_cnt_r + 10'h001 : 10'h000;
            seen_idle_r <= seen_idle_r | !LOG_BUSY;
        end
    end
    one_wait_a: assert property ((PSEL && !PENABLE) ##1 (PSEL && PENABLE) |=> PREADY)
        else $error("no answer after one wait state");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");
    ready_cause_a: assert property (PREADY |-> $past(PSEL && PENABLE))
        else $error("ready without an access");
    err_in_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("slave error outside the answer cycle");
    elog_ro_a: assert property (PREADY && PWRITE && PADDR[11:9] == 3'h1 |-> PSLVERR)
        else $error("write to error log sector not refused");
    unmapped_a: assert property (PREADY && PADDR > elsb_pkg::ADDR_COUNT |-> PSLVERR)
        else $error("unmapped access not refused");
    busy_rise_a: assert property (ERR_VALID && !ERR_REJECTED && !LOG_BUSY |=> LOG_BUSY)
        else $error("accepted error did not start a record");
    reject_quiet_a: assert property (ERR_VALID && ERR_REJECTED && !LOG_BUSY |=> !LOG_BUSY)
        else $error("rejected command started a record");
    rec_len_a: assert property ($fell(LOG_BUSY) && seen_idle_r |-> busy_cnt_r == 10'h07c)
        else $error("record write length wrong");
endmodule // elsb_checker
bind elsb_top elsb_checker i_elsb_checker (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .ERR_VALID(ERR_VALID), .ERR_REJECTED(ERR_REJECTED),
    .LOG_BUSY(LOG_BUSY));
`default_nettype wire

// ==== dv/elsb_host.sv ====
/* Host adapter model: APB master reading and writing the log sectors.
   Assumes one clock; the bench calls xfer for each transfer. */
`timescale 1ns/1ps
`default_nettype none
module elsb_host (
    // Clock
    input wire logic clk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // Request held until pready seen at an edge; bounded so a hang is reported
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e, output logic t);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        q = prdata;
        e = pslverr;
        t = (n >= 64);
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // Stale data must not look valid
    endtask
endmodule // elsb_host
`default_nettype wire

// ==== dv/tb_elsb_top.sv ====
/* Bench for elsb_top: directory and error log sectors read over APB.
   Assumes the host model and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module tb_elsb_top;
    logic MCLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, TF_WE, e;
    logic ERR_VALID, ERR_REJECTED, LOG_BUSY;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, TS_MS, q, sum;
    logic [7:0] TF_WDATA, ERR_CODE;
    logic [2:0] TF_REG;
    logic [3:0] POWER_STATE;
    int fails, samples_checked;
    elsb_top i_elsb_top (.MCLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .TF_WE, .TF_REG, .TF_WDATA, .TS_MS, .POWER_STATE,
        .ERR_VALID, .ERR_REJECTED, .ERR_CODE, .ERR_COUNT_PAIR(16'h0000),
        .ERR_SECTOR_PAIR(16'h5aa5), .ERR_CYL_LO_PAIR(16'h0000), .ERR_CYL_HI_PAIR(16'h0000),
        .ERR_DEVHEAD(8'h00), .ERR_STATUS(~ERR_CODE), .LIFE_HOURS(TS_MS[15:0]), .LOG_BUSY);
    elsb_host i_elsb_host (.clk(MCLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
        .paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus access; a timeout ends the run
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        logic t;
        i_elsb_host.xfer(wr, a, d, q, e, t);
        if (t) begin
            fails++;
            conclude();
        end
    endtask
    task automatic rdw(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(q, exp);
    endtask
    task automatic wrw(input logic [11:0] a, input logic [31:0] d, input logic ex);
        bus(1'b1, a, d);
        check({31'h0, e}, {31'h0, ex});
    endtask
    task automatic rdb(input logic [11:0] b, input logic [7:0] exp);
        bus(1'b0, {b[11:2], 2'b00}, 32'h0);
        check({24'h0, q[8*b[1:0] +: 8]}, {24'h0, exp});
    endtask
    task automatic tfw(input logic [2:0] r, input logic [7:0] d);
        @(posedge MCLK);
        TF_WE <= 1'b1;
        TF_REG <= r;
        TF_WDATA <= d;
        @(posedge MCLK);
        TF_WE <= 1'b0;
    endtask
    task automatic err(input logic rej, input logic [7:0] c);
        @(posedge MCLK);
        ERR_VALID <= 1'b1;
        ERR_REJECTED <= rej;
        ERR_CODE <= c;
        @(posedge MCLK);
        ERR_VALID <= 1'b0;
    endtask
    // Wait for the writer to go idle, bounded above the clear pass
    task automatic idle_wait();
        int n;
        n = 0;
        @(posedge MCLK);
        while (LOG_BUSY !== 1'b0 && n < 1000) begin
            @(posedge MCLK);
            n++;
        end
        if (n >= 1000) begin
            fails++;
            conclude();
        end
    endtask
    task automatic t_dir();
        rdw(12'h000, 32'h0000_0001);
        rdw(12'h004, 32'h0001_0000);
        rdw(12'h100, 32'h0010_0010);
        rdw(12'h140, 32'h0000_0000);
        wrw(12'h1fc, 32'h1234_5678, 1'b0);
        rdw(12'h1fc, 32'h1234_5678);
        wrw(12'h000, 32'habcd_0005, 1'b1);
        rdw(12'h000, 32'habcd_0001);
        wrw(elsb_pkg::ADDR_CTRL, 32'h0, 1'b0);
        rdw(12'h000, 32'habcd_0000);
        wrw(elsb_pkg::ADDR_CTRL, 32'h1, 1'b0);
        wrw(12'h200, 32'hffff_ffff, 1'b1);
        wrw(12'h40c, 32'h0, 1'b1);
        $display("directory test done");
    endtask
    task automatic t_elog();
        logic [11:0] base;
        idle_wait();
        rdw(12'h200, 32'h0000_0001);
        err(1'b1, 8'h55);
        rdw(12'h3f4, 32'h0);
        for (int k = 1; k <= 5; k++) begin
            base = 12'h204 + 12'(124 * ((k - 1) % 4));
            POWER_STATE <= 4'(k % 5);
            TS_MS <= 32'(k);
            tfw(elsb_pkg::TF_COUNT, 8'(k));
            tfw(elsb_pkg::TF_COMMAND, 8'(32'h20 + k));
            err(1'b0, 8'(32'h40 + k));
            idle_wait();
            rdw(12'h200, {16'(((k - 1) % 4) + 1), 16'h0001});
            rdw(12'h3f4, 32'(k));
            rdb(base + 12'h054, 8'(32'h20 + k));
            rdb(base + 12'h04c, 8'(k - 1));
            rdb(base + 12'h05b, 8'(32'h40 + k));
            rdb(base + 12'h079, 8'(k % 5));
            rdb(base + 12'h05f, 8'h5a);
            if (k == 1)
                rdw(12'h280, 32'h0);
        end
        err(1'b0, 8'h66);
        err(1'b0, 8'h67);
        rdw(elsb_pkg::ADDR_STATUS, 32'h301);
        idle_wait();
        rdw(elsb_pkg::ADDR_COUNT, 32'h7);
        sum = 32'h0;
        for (int w = 0; w < 128; w++) begin
            bus(1'b0, 12'h200 + 12'(4 * w), 32'h0);
            sum = sum + q[7:0] + q[15:8] + q[23:16] + q[31:24];
        end
        check({24'h0, sum[7:0]}, 32'h0);
        $display("error log test done");
    endtask
    // Clock at 125 MHz
    initial begin
        MCLK = 1'b0;
        forever #4 MCLK = ~MCLK;
    end
    // Main sequence
    initial begin
        RST_N = 1'b0;
        TF_WE = 1'b0;
        TF_REG = 3'h0;
        TF_WDATA = 8'h00;
        TS_MS = 32'h0;
        POWER_STATE = 4'h0;
        ERR_VALID = 1'b0;
        ERR_REJECTED = 1'b0;
        ERR_CODE = 8'h00;
        fails = 0;
        samples_checked = 0;
        repeat (8) @(posedge MCLK);
        RST_N <= 1'b1;
        t_dir();
        t_elog();
        conclude();
    end
endmodule // tb_elsb_top
`default_nettype wire
